// ==== rtl/tcu_map.vh ====
`ifndef TCU_MAP_VH
`define TCU_MAP_VH
// Register byte offsets
`define TCU_OFS_COUNTER 12'h100
`define TCU_OFS_GRA 12'h104
`define TCU_OFS_GRB 12'h108
`define TCU_OFS_GRC 12'h10c
`define TCU_OFS_GRD 12'h110
`define TCU_OFS_CTRL1 12'h114
`define TCU_OFS_MODE 12'h118
`define TCU_OFS_STATUS 12'h11c
`define TCU_OFS_IOC0 12'h124
`define TCU_OFS_IOC1 12'h128
`define TCU_OFS_FILTER 12'h12c
`define TCU_OFS_OUTEN 12'h130
`define TCU_OFS_CTRL2 12'h134
// Reset values
`define TCU_RST_IOC 8'h88
`define TCU_RST_OUTEN 8'h7f
// Count source codes
`define TCU_SRC_EXT 3'h5
`define TCU_SRC_FAST 3'h6
`define TCU_SRC_ALT 3'h7
// Operating modes in the mode register
`define TCU_MODE_TIMER 2'h0
`define TCU_MODE_PWM 2'h1
`define TCU_MODE_SINGLE_SHOT_PULSE_MODE 2'h2
// Filter sampling clock codes
`define TCU_FCK_DIV32 2'h0
`define TCU_FCK_DIV8 2'h1
`define TCU_FCK_DIV1 2'h2
// Edge codes
`define TCU_EDGE_RISE 2'h0
`define TCU_EDGE_FALL 2'h1
`define TCU_EDGE_BOTH 2'h2
// Field positions
`define TCU_MODE_RUN 3
`define TCU_MODE_BFC 4
`define TCU_MODE_BFD 5
`define TCU_CTRL1_CLR 7
`define TCU_OUTEN_CUT 7
`define TCU_STAT_OVF 7
// Filter agreement count
`define TCU_FILT_MATCH 3
`endif

// ==== rtl/tcu_timer.v ====
// Functional notes
// - Three-bit source field picks prescaled, external rising, fast or alt clock.
// - Buffer bits make C the buffer of A and D the buffer of B.
// - Buffered capture moves A (or B) into its buffer, then latches counter.
// - Buffered compare/PWM copies buffer into A (or B) on its match.
// - SINGLE_SHOT_PULSE_MODE with buffering copies D into B on A match or trigger.
// - Buffered compare sets C/D flag when counter equals buffer register.
// - Buffered capture sets C/D flag on valid edge at C/D pin.
// - Filtered input takes a new level after three equal samples.
// - Filter sample clock: 00 div32, 01 div8, 10 undivided, 11 source.
// - Pin drives timer output in compare modes only while its disable is 0.
// - Low cutoff pin with cutoff enabled sets all four disable bits.
// - Outputs fall back to port use within one or two clocks.
// - Valid capture edge copies counter into that channel's register, except at C/D while that register is a buffer.
// - Capture mode counts up over the full 16-bit range of 65,536.
// - Run bit 1 counts, 0 stops and holds counter value.
// - Capture events and overflow each raise an interrupt request.
// - Edge field: 00 rising, 01 falling, 10 both, 11 prohibited.
// - A source bit: 0 slow oscillator divided signal, 1 the A pin.
// - Counter read/write any time; clear on A compare match or A capture selectable.
//
// Our own choice: register access over Wishbone.
`include "tcu_map.vh"
module tcu_timer #(
  parameter CW = 16
) (
  input wire sys_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire chan_pin_a,
  input wire chan_pin_b,
  input wire chan_pin_c,
  input wire chan_pin_d,
  input wire trigger_pin,
  input wire ext_count_clock_pin,
  input wire fast_osc_clock,
  input wire fast_osc_alt_clock,
  input wire slow_osc_div_signal,
  input wire cutoff_interrupt_pin,
  output reg [3:0] chan_out_q,
  output reg [3:0] chan_oe_q,
  output reg timer_irq_q
);

  // Registers
  reg [CW-1:0] main_counter_q;
  reg [CW-1:0] general_reg_a_q;
  reg [CW-1:0] general_reg_b_q;
  reg [CW-1:0] general_reg_c_q;
  reg [CW-1:0] general_reg_d_q;
  reg [7:0] timer_control_1_q;
  reg [7:0] timer_mode_reg_q;
  reg [7:0] timer_status_reg_q;
  reg [7:0] io_control_0_q;
  reg [7:0] io_control_1_q;
  reg [7:0] input_filter_sel_q;
  reg [7:0] output_master_enable_q;
  reg [7:0] timer_control_2_q;
  reg [4:0] presc_q;
  reg [2:0] src_prev_q;
  reg [4:0] raw_prev_q;
  reg trig_prev_q;
  reg slow_prev_q;

  // Field aliases
  wire [2:0] count_source_sel = timer_control_1_q[6:4];
  wire count_run = timer_mode_reg_q[`TCU_MODE_RUN];
  wire buffer_c_enable = timer_mode_reg_q[`TCU_MODE_BFC];
  wire buffer_d_enable = timer_mode_reg_q[`TCU_MODE_BFD];
  wire [1:0] op_mode = timer_mode_reg_q[1:0];
  wire [1:0] chan_a_edge_sel = io_control_0_q[1:0];
  wire chan_a_mode_sel = io_control_0_q[2];
  wire chan_a_capture_source = io_control_0_q[3];
  wire [1:0] chan_b_edge_sel = io_control_0_q[5:4];
  wire chan_b_mode_sel = io_control_0_q[6];
  wire [1:0] chan_c_edge_sel = io_control_1_q[1:0];
  wire chan_c_mode_sel = io_control_1_q[2];
  wire [1:0] chan_d_edge_sel = io_control_1_q[5:4];
  wire chan_d_mode_sel = io_control_1_q[6];
  wire [1:0] filter_clock_sel = input_filter_sel_q[7:6];
  wire [3:0] chan_output_disable = output_master_enable_q[3:0];
  wire cutoff_input_enable = output_master_enable_q[`TCU_OUTEN_CUT];
  wire [1:0] trig_edge_sel = timer_control_2_q[7:6];

  // Edge test against a two-bit edge field
  function edge_hit;
    input [1:0] sel;
    input prev;
    input cur;
    begin
      case (sel)
        `TCU_EDGE_RISE: edge_hit = cur & ~prev;
        `TCU_EDGE_FALL: edge_hit = ~cur & prev;
        `TCU_EDGE_BOTH: edge_hit = cur ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Free prescaler for divided rates
  always @(posedge sys_clk) begin
    if (!resetn) begin
      presc_q <= 5'h00;
    end else begin
      presc_q <= presc_q + 5'h01;
    end
  end

  // Sampled clock-like sources for edge detection
  always @(posedge sys_clk) begin
    if (!resetn) begin
      src_prev_q <= 3'h0;
    end else begin
      src_prev_q <= {fast_osc_alt_clock, fast_osc_clock, ext_count_clock_pin};
    end
  end

  // Count source tick
  reg src_tick;
  always @* begin
    case (count_source_sel)
      3'h0: src_tick = 1'b1;
      3'h1: src_tick = presc_q[0];
      3'h2: src_tick = &presc_q[1:0];
      3'h3: src_tick = &presc_q[2:0];
      3'h4: src_tick = &presc_q;
      `TCU_SRC_EXT: src_tick = ext_count_clock_pin & ~src_prev_q[0];
      `TCU_SRC_FAST: src_tick = fast_osc_clock & ~src_prev_q[1];
      `TCU_SRC_ALT: src_tick = fast_osc_alt_clock & ~src_prev_q[2];
      default: src_tick = 1'b0;
    endcase
  end
  wire cnt_tick = count_run & src_tick;

  // Filter sample enable
  reg filt_tick;
  always @* begin
    case (filter_clock_sel)
      `TCU_FCK_DIV32: filt_tick = &presc_q;
      `TCU_FCK_DIV8: filt_tick = &presc_q[2:0];
      `TCU_FCK_DIV1: filt_tick = 1'b1;
      default: filt_tick = src_tick;
    endcase
  end

  // Digital filters for pins A..D and trigger
  wire [4:0] raw_in = {trigger_pin, chan_pin_d, chan_pin_c, chan_pin_b,
                       chan_pin_a};
  wire [4:0] filt_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_filt
      reg [`TCU_FILT_MATCH-1:0] smp_q;
      reg lvl_q;
      always @(posedge sys_clk) begin
        if (!resetn) begin
          smp_q <= {`TCU_FILT_MATCH{1'b0}};
          lvl_q <= 1'b0;
        end else if (filt_tick) begin
          smp_q <= {smp_q[`TCU_FILT_MATCH-2:0], raw_in[gi]};
          if (&smp_q)
            lvl_q <= 1'b1;
          else if (~|smp_q)
            lvl_q <= 1'b0;
        end
      end
      assign filt_lvl[gi] = input_filter_sel_q[gi] ? lvl_q : raw_in[gi];
    end
  endgenerate

  // Previous levels for edge detection
  always @(posedge sys_clk) begin
    if (!resetn) begin
      raw_prev_q <= 5'h00;
      slow_prev_q <= 1'b0;
    end else begin
      raw_prev_q <= filt_lvl;
      slow_prev_q <= slow_osc_div_signal;
    end
  end

  // Capture and compare conditions
  wire timer_mode = (op_mode == `TCU_MODE_TIMER);
  wire cap_a_mode = timer_mode & chan_a_mode_sel;
  wire cap_b_mode = timer_mode & chan_b_mode_sel;
  wire cap_c_mode = timer_mode & chan_c_mode_sel;
  wire cap_d_mode = timer_mode & chan_d_mode_sel;
  wire a_src_cur = chan_a_capture_source ? filt_lvl[0] : slow_osc_div_signal;
  wire a_src_prev = chan_a_capture_source ? raw_prev_q[0] : slow_prev_q;
  wire cap_a = cap_a_mode & edge_hit(chan_a_edge_sel, a_src_prev,
                                     a_src_cur);
  wire cap_b = cap_b_mode & edge_hit(chan_b_edge_sel, raw_prev_q[1],
                                     filt_lvl[1]);
  wire cap_c = cap_c_mode & edge_hit(chan_c_edge_sel, raw_prev_q[2],
                                     filt_lvl[2]);
  wire cap_d = cap_d_mode & edge_hit(chan_d_edge_sel, raw_prev_q[3],
                                     filt_lvl[3]);
  wire trig_evt = (op_mode == `TCU_MODE_SINGLE_SHOT_PULSE_MODE) &
                  edge_hit(trig_edge_sel - 2'h1, raw_prev_q[4], filt_lvl[4]) &
                  (trig_edge_sel != 2'h0);
  wire mat_a = cnt_tick & ~cap_a_mode & (main_counter_q == general_reg_a_q);
  wire mat_b = cnt_tick & ~cap_b_mode & (main_counter_q == general_reg_b_q);
  wire mat_c = cnt_tick & ~cap_c_mode & (main_counter_q == general_reg_c_q);
  wire mat_d = cnt_tick & ~cap_d_mode & (main_counter_q == general_reg_d_q);
  wire ovf = cnt_tick & (&main_counter_q);
  wire clr_evt = timer_control_1_q[`TCU_CTRL1_CLR] & (cap_a | mat_a);

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire wr_lo = bus_wr & wb_sel_i[0];
  wire wr_hi = bus_wr & wb_sel_i[1];
  wire [CW-1:0] wr_val = wb_dat_i[CW-1:0];
  function [CW-1:0] merge;
    input [CW-1:0] old;
    begin
      merge = {wr_hi ? wr_val[15:8] : old[15:8],
               wr_lo ? wr_val[7:0] : old[7:0]};
    end
  endfunction

  // Counter: software write, clear, wrap
  always @(posedge sys_clk) begin
    if (!resetn) begin
      main_counter_q <= {CW{1'b0}};
    end else if (bus_wr && wb_adr_i == `TCU_OFS_COUNTER) begin
      main_counter_q <= merge(main_counter_q);
    end else if (clr_evt) begin
      main_counter_q <= {CW{1'b0}};
    end else if (cnt_tick) begin
      main_counter_q <= main_counter_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // General registers A and C
  always @(posedge sys_clk) begin
    if (!resetn) begin
      general_reg_a_q <= {CW{1'b0}};
      general_reg_c_q <= {CW{1'b0}};
    end else begin
      if (wr_lo | wr_hi) begin
        if (wb_adr_i == `TCU_OFS_GRA)
          general_reg_a_q <= merge(general_reg_a_q);
        if (wb_adr_i == `TCU_OFS_GRC)
          general_reg_c_q <= merge(general_reg_c_q);
      end
      if (cap_a) begin
        general_reg_a_q <= main_counter_q;
        if (buffer_c_enable)
          general_reg_c_q <= general_reg_a_q;
      end else if (mat_a && buffer_c_enable) begin
        general_reg_a_q <= general_reg_c_q;
      end
      if (cap_c && !buffer_c_enable)
        general_reg_c_q <= main_counter_q;
    end
  end

  // General registers B and D
  wire single_shot_pulse_mode_load = (op_mode == `TCU_MODE_SINGLE_SHOT_PULSE_MODE) & buffer_d_enable &
                   (mat_a | trig_evt);
  always @(posedge sys_clk) begin
    if (!resetn) begin
      general_reg_b_q <= {CW{1'b0}};
      general_reg_d_q <= {CW{1'b0}};
    end else begin
      if (wr_lo | wr_hi) begin
        if (wb_adr_i == `TCU_OFS_GRB)
          general_reg_b_q <= merge(general_reg_b_q);
        if (wb_adr_i == `TCU_OFS_GRD)
          general_reg_d_q <= merge(general_reg_d_q);
      end
      if (cap_b) begin
        general_reg_b_q <= main_counter_q;
        if (buffer_d_enable)
          general_reg_d_q <= general_reg_b_q;
      end else if (single_shot_pulse_mode_load) begin
        general_reg_b_q <= general_reg_d_q;
      end else if (mat_b && buffer_d_enable &&
                   op_mode != `TCU_MODE_SINGLE_SHOT_PULSE_MODE) begin
        general_reg_b_q <= general_reg_d_q;
      end
      if (cap_d && !buffer_d_enable)
        general_reg_d_q <= main_counter_q;
    end
  end

  // Control registers
  always @(posedge sys_clk) begin
    if (!resetn) begin
      timer_control_1_q <= 8'h00;
      timer_mode_reg_q <= 8'h00;
      io_control_0_q <= `TCU_RST_IOC;
      io_control_1_q <= `TCU_RST_IOC;
      input_filter_sel_q <= 8'h00;
      timer_control_2_q <= 8'h00;
    end else if (wr_lo) begin
      case (wb_adr_i)
        `TCU_OFS_CTRL1: timer_control_1_q <= wb_dat_i[7:0];
        `TCU_OFS_MODE: timer_mode_reg_q <= wb_dat_i[7:0];
        `TCU_OFS_IOC0: io_control_0_q <= {1'b1, wb_dat_i[6:0]};
        `TCU_OFS_IOC1: io_control_1_q <= wb_dat_i[7:0];
        `TCU_OFS_FILTER: input_filter_sel_q <= wb_dat_i[7:0] & 8'hdf;
        `TCU_OFS_CTRL2: timer_control_2_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Output disable bits with forced cutoff
  wire cutoff_hit = cutoff_input_enable & ~cutoff_interrupt_pin;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      output_master_enable_q <= `TCU_RST_OUTEN;
    end else begin
      if (wr_lo && wb_adr_i == `TCU_OFS_OUTEN)
        output_master_enable_q <= wb_dat_i[7:0] | 8'h70;
      if (cutoff_hit)
        output_master_enable_q[3:0] <= 4'hf;
    end
  end

  // Status flags, write 1 clears, set wins
  wire [7:0] flag_set;
  assign flag_set[0] = cap_a | mat_a;
  assign flag_set[1] = cap_b | mat_b;
  assign flag_set[2] = cap_c | mat_c;
  assign flag_set[3] = cap_d | mat_d;
  assign flag_set[6:4] = 3'h0;
  assign flag_set[`TCU_STAT_OVF] = ovf;
  wire [7:0] flag_clr = (wr_lo && wb_adr_i == `TCU_OFS_STATUS) ?
                        wb_dat_i[7:0] : 8'h00;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      timer_status_reg_q <= 8'h00;
    end else begin
      timer_status_reg_q <= (timer_status_reg_q & ~flag_clr) | flag_set;
    end
  end

  // Interrupt request pulse
  always @(posedge sys_clk) begin
    if (!resetn) begin
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= |flag_set;
    end
  end

  // Compare outputs toggle on match; pin driven only while enabled
  wire [3:0] cmp_mode = {~cap_d_mode, ~cap_c_mode, ~cap_b_mode, ~cap_a_mode};
  wire [3:0] mat_vec = {mat_d, mat_c, mat_b, mat_a};
  always @(posedge sys_clk) begin
    if (!resetn) begin
      chan_out_q <= 4'h0;
      chan_oe_q <= 4'h0;
    end else begin
      chan_out_q <= chan_out_q ^ (mat_vec & cmp_mode);
      chan_oe_q <= cmp_mode & ~chan_output_disable &
                   ~{4{cutoff_hit}};
    end
  end

  // Read data mux
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (wb_adr_i)
      `TCU_OFS_COUNTER: rd_val[CW-1:0] = main_counter_q;
      `TCU_OFS_GRA: rd_val[CW-1:0] = general_reg_a_q;
      `TCU_OFS_GRB: rd_val[CW-1:0] = general_reg_b_q;
      `TCU_OFS_GRC: rd_val[CW-1:0] = general_reg_c_q;
      `TCU_OFS_GRD: rd_val[CW-1:0] = general_reg_d_q;
      `TCU_OFS_CTRL1: rd_val[7:0] = timer_control_1_q;
      `TCU_OFS_MODE: rd_val[7:0] = timer_mode_reg_q;
      `TCU_OFS_STATUS: rd_val[7:0] = timer_status_reg_q;
      `TCU_OFS_IOC0: rd_val[7:0] = io_control_0_q;
      `TCU_OFS_IOC1: rd_val[7:0] = io_control_1_q;
      `TCU_OFS_FILTER: rd_val[7:0] = input_filter_sel_q;
      `TCU_OFS_OUTEN: rd_val[7:0] = output_master_enable_q;
      `TCU_OFS_CTRL2: rd_val[7:0] = timer_control_2_q;
      default: rd_val = 32'h00000000;
    endcase
  end

  // Wishbone acknowledge, one wait state
  always @(posedge sys_clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_val : 32'h00000000;
    end
  end

endmodule // tcu_timer

// ==== tb/tcu_props.sv ====
`include "tcu_map.vh"
module tcu_props (
  input wire sys_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire cutoff_interrupt_pin,
  input wire [3:0] chan_oe_q,
  input wire timer_irq_q
);
  reg cut_en_q;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_en = req && wb_we_i && wb_sel_i[0];
  wire cut_low = cut_en_q && !cutoff_interrupt_pin;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Shadow of the cutoff enable bit
  always @(posedge sys_clk) begin
    if (!resetn)
      cut_en_q <= 1'b0;
    else if (wr_en && wb_adr_i == `TCU_OFS_OUTEN)
      cut_en_q <= wb_dat_i[7];
  end
  // Bus answer timing
  property p_ack_next; req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_req; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without req");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
  // Reset state of outputs
  property p_rst;
    disable iff (1'b0)
    !resetn |=> chan_oe_q == 4'h0 && !timer_irq_q && !wb_ack_o;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  // Cutoff drops the pin drivers
  property p_cut_fast; cut_low |-> ##[1:2] chan_oe_q == 4'h0; endproperty
  a_cut_fast: assert property (p_cut_fast) else $error("cutoff slow");
  property p_cut_hold;
    cut_low && $past(cut_low) |-> chan_oe_q == 4'h0;
  endproperty
  a_cut_hold: assert property (p_cut_hold) else $error("cutoff lost");
  // Drivers only come on after a register write
  property p_oe_rise;
    |(chan_oe_q & ~$past(chan_oe_q)) |-> (wb_we_i && wb_ack_o)
      || $past(wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("oe rose alone");
endmodule // tcu_props
bind tcu_timer tcu_props u_props (.sys_clk(sys_clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cutoff_interrupt_pin(cutoff_interrupt_pin), .chan_oe_q(chan_oe_q),
  .timer_irq_q(timer_irq_q));

// ==== tb/tcu_src.sv ====
module tcu_src (
  input wire sys_clk,
  output reg ext_count_clock_pin,
  output reg fast_osc_clock,
  output reg fast_osc_alt_clock,
  output reg slow_osc_div_signal
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sources stand low between bursts
  initial begin
    ext_count_clock_pin = 1'b0;
    fast_osc_clock = 1'b0;
    fast_osc_alt_clock = 1'b0;
    slow_osc_div_signal = 1'b0;
  end
  // One line of the chosen source, high four clocks and low five each
  task ticks(input [2:0] code, input integer n);
    integer i;
    for (i = 0; i < n; i++) begin
      @(posedge sys_clk);
      case (code)
        3'h5: ext_count_clock_pin <= 1'b1;
        3'h6: fast_osc_clock <= 1'b1; // Oscillator on first
        3'h7: fast_osc_alt_clock <= 1'b1;
        default: slow_osc_div_signal <= 1'b1;
      endcase
      repeat (4) @(posedge sys_clk);
      ext_count_clock_pin <= 1'b0;
      fast_osc_clock <= 1'b0;
      fast_osc_alt_clock <= 1'b0;
      slow_osc_div_signal <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // tcu_src

// ==== tb/tcu_timer_test.sv ====
`include "tcu_map.vh"
module tcu_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  reg sys_clk, resetn, cyc, stb, we, trig, cut_n;
  reg [11:0] adr;
  reg [31:0] wdat, q;
  reg [3:0] sel, chp;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, timer_irq_q, ext_ck, fck, ack_alt, slow;
  wire [3:0] chan_oe_q, chan_out;
  integer fail_count, checked, cyc_n, irq_n, n0, k;
  tcu_src u_src (.sys_clk(sys_clk), .ext_count_clock_pin(ext_ck),
    .fast_osc_clock(fck), .fast_osc_alt_clock(ack_alt),
    .slow_osc_div_signal(slow));
  tcu_timer DUT (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .chan_pin_a(chp[0]), .chan_pin_b(chp[1]), .chan_pin_c(chp[2]),
    .chan_pin_d(chp[3]), .trigger_pin(trig), .ext_count_clock_pin(ext_ck),
    .fast_osc_clock(fck), .fast_osc_alt_clock(ack_alt),
    .slow_osc_div_signal(slow), .cutoff_interrupt_pin(cut_n),
    .chan_out_q(chan_out), .chan_oe_q(chan_oe_q),
    .timer_irq_q(timer_irq_q));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Cycle limit and interrupt pulse count
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (timer_irq_q === 1'b1) irq_n <= irq_n + 1;
    if (cyc_n == 20000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    checked = checked + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Classic single cycle, held until ack
  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1) @(posedge sys_clk);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input [11:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task pin(input integer i, input v, input integer n);
    @(posedge sys_clk);
    chp[i] <= v;
    repeat (n) @(posedge sys_clk);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {fail_count, checked, cyc_n, irq_n} = 0;
    {resetn, cyc, stb, we, trig, adr, wdat, sel, chp} = 0;
    cut_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    // Reset values and unmapped space
    rd(`TCU_OFS_IOC0, 32'h88);
    rd(`TCU_OFS_IOC1, 32'h88);
    rd(`TCU_OFS_OUTEN, 32'h7f);
    rd(`TCU_OFS_COUNTER, 32'h0);
    wr(12'h200, 32'hff);
    rd(12'h200, 32'h0);
    wr(`TCU_OFS_FILTER, 32'hff);
    rd(`TCU_OFS_FILTER, 32'hdf);
    wr(`TCU_OFS_FILTER, 32'h0);
    // Each outside source counts, stop holds
    for (k = 5; k < 8; k++) begin
      wr(`TCU_OFS_CTRL1, k << 4);
      wr(`TCU_OFS_COUNTER, 32'h10);
      wr(`TCU_OFS_MODE, 32'h08);
      u_src.ticks(k[2:0], 3);
      wr(`TCU_OFS_MODE, 32'h0);
      u_src.ticks(k[2:0], 2);
      rd(`TCU_OFS_COUNTER, 32'h13);
    end
    // Wrap past the top and overflow request
    wr(`TCU_OFS_CTRL1, 32'h50);
    wr(`TCU_OFS_COUNTER, 32'hfffe);
    wr(`TCU_OFS_STATUS, 32'hff);
    n0 = irq_n;
    wr(`TCU_OFS_MODE, 32'h08);
    u_src.ticks(3'h5, 3);
    wr(`TCU_OFS_MODE, 32'h0);
    rd(`TCU_OFS_COUNTER, 32'h1);
    // Counter passes zero too, so all four compare flags join overflow
    rd(`TCU_OFS_STATUS, 32'h8f);
    chk("irq count", irq_n - n0, 32'h2);
    // Edge codes on channel A, counter moved by bus between edges
    for (k = 0; k < 4; k++) begin
      wr(`TCU_OFS_GRA, 32'hab);
      wr(`TCU_OFS_IOC0, 32'h0c | k); // Capture mode
      wr(`TCU_OFS_COUNTER, 32'h11);
      pin(0, 1'b1, 6);
      wr(`TCU_OFS_COUNTER, 32'h22);
      pin(0, 1'b0, 6);
      rd(`TCU_OFS_GRA, k == 0 ? 32'h11 : k == 3 ? 32'hab : 32'h22);
    end
    // Slow oscillator as capture source, pin ignored
    wr(`TCU_OFS_IOC0, 32'h04);
    wr(`TCU_OFS_COUNTER, 32'h44);
    pin(0, 1'b1, 6);
    pin(0, 1'b0, 6);
    wr(`TCU_OFS_COUNTER, 32'h33);
    u_src.ticks(3'h0, 1);
    rd(`TCU_OFS_GRA, 32'h33);
    // Buffered capture, C in step with A
    wr(`TCU_OFS_MODE, 32'h10);
    wr(`TCU_OFS_IOC0, 32'h0c);
    wr(`TCU_OFS_IOC1, 32'h8c);
    for (k = 1; k < 3; k++) begin
      wr(`TCU_OFS_COUNTER, k << 8);
      pin(0, 1'b1, 6);
      pin(0, 1'b0, 6);
    end
    rd(`TCU_OFS_GRA, 32'h200);
    rd(`TCU_OFS_GRC, 32'h100);
    wr(`TCU_OFS_STATUS, 32'hff);
    pin(2, 1'b1, 6);
    pin(2, 1'b0, 6);
    rd(`TCU_OFS_STATUS, 32'h04);
    // Filter rejects a two-cycle glitch
    wr(`TCU_OFS_MODE, 32'h0);
    wr(`TCU_OFS_FILTER, 32'h81);
    wr(`TCU_OFS_COUNTER, 32'h55);
    pin(0, 1'b1, 1);
    pin(0, 1'b0, 10);
    rd(`TCU_OFS_GRA, 32'h200); // Two-sample glitch ignored
    wr(`TCU_OFS_COUNTER, 32'h66);
    pin(0, 1'b1, 12);
    pin(0, 1'b0, 12);
    rd(`TCU_OFS_GRA, 32'h66);
    wr(`TCU_OFS_FILTER, 32'h0);
    // Buffered compare: reload A, match flag for C
    wr(`TCU_OFS_IOC0, 32'h88);
    wr(`TCU_OFS_IOC1, 32'h88);
    wr(`TCU_OFS_COUNTER, 32'h3);
    wr(`TCU_OFS_GRA, 32'h5);
    wr(`TCU_OFS_GRC, 32'h9);
    wr(`TCU_OFS_STATUS, 32'hff);
    wr(`TCU_OFS_MODE, 32'h18);
    u_src.ticks(3'h5, 3);
    rd(`TCU_OFS_GRA, 32'h9);
    u_src.ticks(3'h5, 4);
    rd(`TCU_OFS_STATUS, 32'h05);
    // Toggles: all four at zero earlier, A twice and C once here
    chk("out", chan_out, 4'hb);
    // Single-shot mode: trigger moves D into B
    wr(`TCU_OFS_MODE, 32'h22);
    wr(`TCU_OFS_CTRL2, 32'h40);
    wr(`TCU_OFS_GRB, 32'h10);
    wr(`TCU_OFS_GRD, 32'h77);
    @(posedge sys_clk);
    trig <= 1'b1;
    repeat (4) @(posedge sys_clk);
    trig <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(`TCU_OFS_GRB, 32'h77);
    // Drivers on, then forced cutoff
    wr(`TCU_OFS_MODE, 32'h0);
    wr(`TCU_OFS_OUTEN, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("oe", chan_oe_q, 4'hf);
    wr(`TCU_OFS_OUTEN, 32'h80); // Cutoff enable set last
    @(posedge sys_clk);
    cut_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("oe cut", chan_oe_q, 4'h0);
    rd(`TCU_OFS_OUTEN, 32'hff);
    cut_n <= 1'b1;
    complete_run;
  end
endmodule // tcu_timer_test
